// ==== src/mos_consts.vh ====
`ifndef MOS_CONSTS_VH
`define MOS_CONSTS_VH

// Sync mode codes
`define MOS_MODE_CTRL 2'h0
`define MOS_MODE_ALONE 2'h1

// Register offsets
`define MOS_ADDR_CTRL 8'h00
`define MOS_ADDR_OUT0 8'h01
`define MOS_ADDR_STAT 8'h08

// Control register fields
`define MOS_CTRL_MODE_LO 0
`define MOS_CTRL_PD_BIT 2

// Output config register fields
`define MOS_OUT_DEL_LO 0
`define MOS_OUT_FD_BIT 6
`define MOS_OUT_EN_BIT 7
`define MOS_OUT_MOD_LO 8

// Reset values
`define MOS_CTRL_RST 3'h1
`define MOS_OUT_RST 14'h0100

// Latencies in clock cycles and driver modulus limit
`define MOS_LAT_ALONE 7'h06
`define MOS_LAT_FSYNC 7'h3E
`define MOS_LAT_FOLLOW 7'h07
`define MOS_LAT_DRV_BASE 7'h06
`define MOS_LAT_DRV_STEP 7'h07
`define MOS_DRV_MAX_MOD 6'h08

`endif

// ==== src/mos_sync.v ====
`timescale 1ns/10ps
`include "mos_consts.vh"

module mos_sync #(
  parameter NOUT = 5
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Sync pin and feedback divider
  input wire sync_pin,
  input wire fb_div_out,
  // Clock outputs
  output wire [NOUT-1:0] differential_clock_output,
  output wire retimed_sync_pulse
);

  // ****************************************
  // Configuration registers
  // ****************************************
  reg [1:0] sync_mode_select_r;
  reg pll_power_down_r;
  reg [13:0] out_cfg_r [0:NOUT-1];
  reg [NOUT-1:0] out_lvl_r;
  reg [NOUT-1:0] busy_w;
  wire is_ctrl;
  wire is_follow;
  wire retime_fb;
  integer k;
  // Reset words; only the control word is split into fields below
  localparam [2:0] CTRL_RST = `MOS_CTRL_RST;
  localparam [13:0] OUT_RST = `MOS_OUT_RST;

  assign is_ctrl = (sync_mode_select_r == `MOS_MODE_CTRL);
  assign is_follow = sync_mode_select_r[1];
  // Divider retiming only while PLL runs and not in follower mode
  assign retime_fb = ~is_follow & ~pll_power_down_r;

  always @(posedge clock) begin
    if (!nrst) begin
      sync_mode_select_r <= CTRL_RST[1:0];
      pll_power_down_r <= CTRL_RST[2];
      for (k = 0; k < NOUT; k = k + 1) begin
        out_cfg_r[k] <= OUT_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == `MOS_ADDR_CTRL) begin
        sync_mode_select_r <= reg_wdata[`MOS_CTRL_MODE_LO+1:`MOS_CTRL_MODE_LO];
        pll_power_down_r <= reg_wdata[`MOS_CTRL_PD_BIT];
      end
      for (k = 0; k < NOUT; k = k + 1) begin
        if (reg_addr == `MOS_ADDR_OUT0 + k[7:0]) begin
          out_cfg_r[k] <= reg_wdata[13:0];
        end
      end
    end
  end

  // ****************************************
  // Control and status words
  // ****************************************
  wire [15:0] ctrl_word;
  wire [15:0] stat_word;

  // Unused upper bits read as zero
  assign ctrl_word = {13'h0000, pll_power_down_r, sync_mode_select_r};
  assign stat_word = {5'h00, busy_w, retimed_sync_pulse, out_lvl_r};

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `MOS_ADDR_CTRL) begin
          reg_rdata <= ctrl_word;
        end else if (reg_addr == `MOS_ADDR_STAT) begin
          reg_rdata <= stat_word;
        end else begin
          for (k = 0; k < NOUT; k = k + 1) begin
            if (reg_addr == `MOS_ADDR_OUT0 + k[7:0]) begin
              reg_rdata <= {2'h0, out_cfg_r[k]};
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Sync input synchronizer and retiming
  // ****************************************
  reg sync_meta_r;
  reg sync_s_r;
  reg fb_prev_r;
  reg retimed_sync_pulse_r;
  reg retimed_sync_pulse_d_r;
  reg retimed_sync_pulse_nxt;
  wire fb_rise;

  // Rising edge of the feedback divider
  assign fb_rise = fb_div_out & ~fb_prev_r;

  always @(posedge clock) begin
    if (!nrst) begin
      fb_prev_r <= 1'b0;
    end else begin
      fb_prev_r <= fb_div_out;
    end
  end

  always @* begin
    retimed_sync_pulse_nxt = retimed_sync_pulse_r;
    if (!retime_fb) begin
      retimed_sync_pulse_nxt = sync_s_r;
    end else if (fb_rise) begin
      retimed_sync_pulse_nxt = sync_s_r;
    end
  end

  always @(posedge clock) begin
    if (!nrst) begin
      sync_meta_r <= 1'b0;
      sync_s_r <= 1'b0;
      retimed_sync_pulse_r <= 1'b0;
      retimed_sync_pulse_d_r <= 1'b0;
    end else begin
      sync_meta_r <= sync_pin;
      sync_s_r <= sync_meta_r;
      retimed_sync_pulse_r <= retimed_sync_pulse_nxt;
      retimed_sync_pulse_d_r <= retimed_sync_pulse_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign retimed_sync_pulse = retimed_sync_pulse_r;
  assign differential_clock_output = out_lvl_r;

  // ****************************************
  // Per-output divider and gate
  // ****************************************
  localparam ST_RUN = 2'h0;
  localparam ST_PARK = 2'h1;
  localparam ST_WAIT = 2'h2;

  // ****************************************
  // Release detect
  // ****************************************
  wire sync_fall;
  // First cycle that retimed sync reads low
  assign sync_fall = retimed_sync_pulse_d_r & ~retimed_sync_pulse_r;

  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_out
      reg [1:0] st_r;
      reg [1:0] st_nxt;
      reg [5:0] cnt_r;
      reg [5:0] cnt_nxt;
      reg [6:0] wait_r;
      reg [6:0] wait_nxt;
      reg lvl_nxt;
      reg [5:0] meff;
      reg [6:0] lat;
      reg [5:0] half;
      reg [5:0] drv_steps;
      reg [6:0] del_ext;
      wire en;
      wire drv;
      wire [5:0] del;
      wire [5:0] mod;

      assign en = out_cfg_r[g][`MOS_OUT_EN_BIT];
      // Drive select counts only in controller mode
      assign drv = is_ctrl & out_cfg_r[g][`MOS_OUT_FD_BIT];
      assign del = out_cfg_r[g][`MOS_OUT_DEL_LO+5:`MOS_OUT_DEL_LO];
      assign mod = out_cfg_r[g][`MOS_OUT_MOD_LO+5:`MOS_OUT_MOD_LO];

      // ****************************************
      // Divider setting and latency
      // ****************************************
      always @* begin
        meff = (mod == 6'h00) ? 6'h01 : mod;
        if (drv && mod > `MOS_DRV_MAX_MOD) begin
          meff = `MOS_DRV_MAX_MOD;
        end
        // Any other modulus passes unchanged
        half = (meff >> 1) + {5'h00, meff[0]};
        drv_steps = `MOS_DRV_MAX_MOD - meff;
        del_ext = {1'b0, del};
        if (drv) begin
          // Delay field unused for drivers
          lat = `MOS_LAT_DRV_BASE + `MOS_LAT_DRV_STEP * {1'b0, drv_steps};
        end else if (is_follow) begin
          lat = `MOS_LAT_FOLLOW + del_ext;
        end else if (is_ctrl) begin
          lat = `MOS_LAT_FSYNC + del_ext;
        end else begin
          lat = `MOS_LAT_ALONE + del_ext;
        end
      end

      // ****************************************
      // Gate state machine
      // ****************************************
      always @* begin
        st_nxt = st_r;
        wait_nxt = wait_r;
        cnt_nxt = (cnt_r + 6'h01 >= meff) ? 6'h00 : cnt_r + 6'h01;
        lvl_nxt = (cnt_nxt < half);
        case (st_r)
          ST_RUN: begin
            // Unenabled outputs never leave this state
            if (en && retimed_sync_pulse_r) begin
              st_nxt = ST_PARK;
            end
          end
          ST_PARK: begin
            if (!out_lvl_r[g]) begin
              cnt_nxt = cnt_r;
              lvl_nxt = 1'b0;
            end
            if (sync_fall) begin
              st_nxt = ST_WAIT;
              wait_nxt = lat;
              cnt_nxt = cnt_r;
              lvl_nxt = 1'b0;
            end
          end
          ST_WAIT: begin
            cnt_nxt = cnt_r;
            lvl_nxt = 1'b0;
            wait_nxt = wait_r - 7'h01;
            if (wait_r == 7'h01) begin
              st_nxt = ST_RUN;
              cnt_nxt = 6'h00;
              lvl_nxt = 1'b1;
            end
          end
          default: begin
            st_nxt = ST_RUN;
          end
        endcase
      end

      always @(posedge clock) begin
        if (!nrst) begin
          st_r <= ST_RUN;
          cnt_r <= 6'h00;
          wait_r <= 7'h00;
          out_lvl_r[g] <= 1'b0;
        end else begin
          st_r <= st_nxt;
          cnt_r <= cnt_nxt;
          wait_r <= wait_nxt;
          out_lvl_r[g] <= lvl_nxt;
        end
      end

      always @* begin
        busy_w[g] = (st_r != ST_RUN);
      end
    end
  endgenerate

endmodule // mos_sync

// ==== tb/mos_sync_chk.sv ====
`timescale 1ns/10ps
`include "mos_consts.vh"
// ******
// Port checker
// ******
module mos_sync_chk #(
  parameter NOUT = 5
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Sync and clocks
  input wire sync_pin,
  input wire fb_div_out,
  input wire [NOUT-1:0] differential_clock_output,
  input wire retimed_sync_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [2:0] ctl_r;
  wire raw = ctl_r[1] || ctl_r[2];
  // Shadow of mode and power-down
  always_ff @(posedge clock) begin
    if (!nrst)
      ctl_r <= 3'h1;
    else if (reg_wr && reg_addr == `MOS_ADDR_CTRL)
      ctl_r <= reg_wdata[2:0];
  end
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  chk_stat_levels: assert property ($past(reg_rd) && $past(reg_addr) == `MOS_ADDR_STAT
    |-> reg_rdata[4:0] == $past(differential_clock_output)) else $error("status levels wrong");
  chk_stat_sync: assert property ($past(reg_rd) && $past(reg_addr) == `MOS_ADDR_STAT
    |-> reg_rdata[5] == $past(retimed_sync_pulse)) else $error("status sync wrong");
  chk_reset_clear: assert property (!$past(nrst) |-> differential_clock_output == 0 && !retimed_sync_pulse)
    else $error("outputs not cleared");
  chk_retime_rise: assert property ($rose(retimed_sync_pulse) |-> $past(sync_pin, 3))
    else $error("sync rose early");
  chk_retime_fall: assert property ($fell(retimed_sync_pulse) |-> !$past(sync_pin, 3))
    else $error("sync fell early");
  chk_plain_retime: assert property (raw && $past(raw) |-> retimed_sync_pulse == $past(sync_pin, 3))
    else $error("sync not plain retimed");
  chk_fb_gate: assert property (!raw && $changed(retimed_sync_pulse) |-> $past(fb_div_out) && !$past(fb_div_out, 2))
    else $error("sync not on divider edge");
endmodule // mos_sync_chk

bind mos_sync mos_sync_chk #(.NOUT(NOUT)) u_chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
  .fb_div_out(fb_div_out), .differential_clock_output(differential_clock_output),
  .retimed_sync_pulse(retimed_sync_pulse));

// ==== tb/mos_peer.sv ====
`timescale 1ns/10ps
// ******
// Shared sync source and feedback divider
// ******
module mos_peer (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Control
  input wire fire,
  // Toward the chip
  output logic sync_pin,
  output logic fb_div_out
);
  logic [2:0] fb_cnt_r;
  logic [7:0] hold_r;
  // One pin shared by all chips, no skew
  assign sync_pin = hold_r != 8'h00;
  assign fb_div_out = fb_cnt_r[2];
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fb_cnt_r <= 3'h0;
      hold_r <= 8'h00;
    end else begin
      fb_cnt_r <= fb_cnt_r + 3'h1;
      // Pulse outlasts every output period so all enabled outputs park
      if (fire)
        hold_r <= 8'h64;
      else if (sync_pin)
        hold_r <= hold_r - 8'h01;
    end
  end
endmodule // mos_peer

// ==== tb/tb_mos_sync.sv ====
`timescale 1ns/10ps
`include "mos_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED at %0t: mismatch", $time); end end
module tb_mos_sync;
  logic clock = 0;
  logic nrst = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic fire = 0;
  logic moved = 0;
  logic [4:0] prev_r;
  wire [15:0] reg_rdata;
  wire sync_pin, fb_div_out, retimed_sync_pulse;
  wire [4:0] dco;
  int since, miscompares, n_checks;
  int rise [5];
  localparam logic [7:0] O = `MOS_ADDR_OUT0;
  mos_peer peer (.clock(clock), .nrst(nrst), .fire(fire), .sync_pin(sync_pin), .fb_div_out(fb_div_out));
  mos_sync dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin), .fb_div_out(fb_div_out),
    .differential_clock_output(dco), .retimed_sync_pulse(retimed_sync_pulse));
  initial begin
    forever #5 clock = ~clock;
  end
  // First rise of each output after sync release
  always @(posedge clock) begin
    prev_r <= dco;
    since <= retimed_sync_pulse ? 0 : since + 1;
    if (retimed_sync_pulse && dco[1] !== prev_r[1])
      moved <= 1;
    for (int i = 0; i < 5; i++) begin
      if (retimed_sync_pulse)
        rise[i] <= -1;
      else if (dco[i] && !prev_r[i] && rise[i] < 0)
        rise[i] <= since;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask
  task automatic sync_run(input logic [4:0] en, input int e [5]);
    @(posedge clock);
    fire <= 1;
    @(posedge clock);
    fire <= 0;
    repeat (50) @(posedge clock);
    rd(`MOS_ADDR_STAT, 16'h07E0, {5'h00, en, 1'b1, 5'h00});
    repeat (350) @(posedge clock);
    for (int i = 0; i < 5; i++)
      if (en[i]) `CHK(rise[i], e[i])
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1;
    rd(`MOS_ADDR_CTRL, 16'hFFFF, 16'h0001);
    rd(O, 16'hFFFF, 16'h0100);
    wr(8'h20, 16'h1234);
    rd(8'h20, 16'hFFFF, 16'h0000);
    rd(`MOS_ADDR_STAT, 16'hF800, 16'h0000);
    wr(`MOS_ADDR_CTRL, 16'h0006);
    wr(O, 16'h0480);
    wr(O + 8'h01, 16'h0200);
    wr(O + 8'h02, 16'h04C3);
    sync_run(5'h05, '{8, 0, 11, 0, 0});
    `CHK(moved, 1'b1)
    wr(`MOS_ADDR_CTRL, 16'h0004);
    wr(O, 16'h0CC5);
    wr(O + 8'h01, 16'h01C0);
    wr(O + 8'h02, 16'h00C0);
    wr(O + 8'h03, 16'h0480);
    wr(O + 8'h04, 16'h28BF);
    sync_run(5'h1F, '{7, 56, 56, 63, 126});
    wr(`MOS_ADDR_CTRL, 16'h0001);
    wr(O + 8'h01, 16'h0CC2);
    wr(O, 16'h0480);
    sync_run(5'h1F, '{7, 9, 7, 7, 70});
    print_verdict;
  end
endmodule // tb_mos_sync
